// ### design/cps_timing_cfg.svh
`ifndef CPS_TIMING_CFG_SVH
`define CPS_TIMING_CFG_SVH

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define CPS_CLK_KHZ        125000
`define CPS_BIAS_DLY_MS    220
`define CPS_BIAS_MIN_MS    100
`define CPS_RETRY_MS       2000
`define CPS_CNT_W          32

// ----------------------------------------------------------------
// Pin positions in the synchronised input vector
// ----------------------------------------------------------------
`define CPS_NUM_PINS       7
`define CPS_PIN_VBUS_UV    0
`define CPS_PIN_VBAT_UV    1
`define CPS_PIN_VBAT_DEPL  2
`define CPS_PIN_SLEEP_EXIT 3
`define CPS_PIN_BOOST      4
`define CPS_PIN_OVERLOAD   5
`define CPS_PIN_SRC_GOOD   6

// Watchdog setting after power-on reset
`define CPS_WDT_RESET      2'h1

`endif

// ### design/cps_pkg.sv
package cps_pkg;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CPS_ST_OFF     = 3'b000,
    CPS_ST_BAT     = 3'b001,
    CPS_ST_HIZ     = 3'b010,
    CPS_ST_QUALIFY = 3'b011,
    CPS_ST_RUN     = 3'b100,
    CPS_ST_RETRY   = 3'b101,
    CPS_ST_BOOST   = 3'b110
  } cps_state_t;

endpackage : cps_pkg

// ### design/cps_sync_if.sv
`include "cps_timing_cfg.svh"

// Raw pin levels in, synchronised levels out
interface cps_sync_if #(
  parameter int W = `CPS_NUM_PINS
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;

  modport user   (output raw, input sync);
  modport syncer (input raw, output sync);
endinterface : cps_sync_if

// ### design/cps_pin_sync.sv
module cps_pin_sync #(
  parameter int W = 7
) (
  input wire logic   ref_clk,
  input wire logic   reset_n,
  input wire logic   clk_en,
  cps_sync_if.syncer pins
);

  // ----------------------------------------------------------------
  // Two-flop synchroniser per pin
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      // First stage feeds only the second stage
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else if (clk_en) begin
          meta_q <= pins.raw[i];
          sync_q <= meta_q;
        end
      end
      assign pins.sync[i] = sync_q;
    end
  endgenerate

endmodule : cps_pin_sync

// ### design/cps_sequencer.sv
// How it works
// - supply rises, registers reset, serial ready
// - battery only, above depletion: close switch
// - battery only: bias regulator stays off
// - overload opens switch until input returns
// - host disable bit opens battery switch
// - adapter attach recloses host-disabled switch
// - check input before bias, limit before buck
// - bias needs release, sleep match, delay
// - sleep match or delay missing: high impedance state
// - qualify source after bias, then buck
// - pass sets power good, output, interrupt
// - failed qualification retried every two seconds
`include "cps_timing_cfg.svh"

module cps_sequencer #(
  parameter int unsigned BIAS_DLY_CYC = `CPS_BIAS_DLY_MS * (`CPS_CLK_KHZ),
  parameter int unsigned RETRY_CYC    = `CPS_RETRY_MS * (`CPS_CLK_KHZ)
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       vbus_above_release,
  input  wire logic       vbat_above_release,
  input  wire logic       vbat_above_depletion,
  input  wire logic       vbus_above_sleep_exit,
  input  wire logic       boost_request_pin,
  input  wire logic       overload_detect,
  input  wire logic       source_good,
  input  wire logic       host_wr,
  input  wire logic       host_wr_switch_disable,
  input  wire logic [1:0] host_wr_watchdog,
  output logic            reg_reset_pulse,
  output logic            serial_ready,
  output logic            battery_switch_disable_bit,
  output logic [1:0]      watchdog_timer_setting,
  output logic            shipping_mode,
  output logic            battery_path_switch_on,
  output logic            internal_bias_regulator_en,
  output logic            high_impedance_state,
  output logic            buck_enable,
  output logic            power_good_status_bit,
  output logic            power_good_output_n,
  output logic            host_int_pulse
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  cps_sync_if #(.W(`CPS_NUM_PINS)) pins ();

  assign pins.raw[`CPS_PIN_VBUS_UV]    = vbus_above_release;
  assign pins.raw[`CPS_PIN_VBAT_UV]    = vbat_above_release;
  assign pins.raw[`CPS_PIN_VBAT_DEPL]  = vbat_above_depletion;
  assign pins.raw[`CPS_PIN_SLEEP_EXIT] = vbus_above_sleep_exit;
  assign pins.raw[`CPS_PIN_BOOST]      = boost_request_pin;
  assign pins.raw[`CPS_PIN_OVERLOAD]   = overload_detect;
  assign pins.raw[`CPS_PIN_SRC_GOOD]   = source_good;

  cps_pin_sync #(.W(`CPS_NUM_PINS)) u_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .pins    (pins)
  );

  logic vbus_ok;
  logic vbat_ok;
  logic depl_ok;
  logic sleep_ok;
  logic boost;
  logic ovl;
  logic src_ok;
  assign vbus_ok  = pins.sync[`CPS_PIN_VBUS_UV];
  assign vbat_ok  = pins.sync[`CPS_PIN_VBAT_UV];
  assign depl_ok  = pins.sync[`CPS_PIN_VBAT_DEPL];
  assign sleep_ok = pins.sync[`CPS_PIN_SLEEP_EXIT];
  assign boost    = pins.sync[`CPS_PIN_BOOST];
  assign ovl      = pins.sync[`CPS_PIN_OVERLOAD];
  assign src_ok   = pins.sync[`CPS_PIN_SRC_GOOD];

  // ----------------------------------------------------------------
  // Power-on detection and edges
  // ----------------------------------------------------------------
  logic supply_ok;
  logic supply_q;
  logic vbus_q;
  logic attach;
  assign supply_ok = vbus_ok | vbat_ok;
  assign attach    = vbus_ok & ~vbus_q;

  // Previous levels for edge finding
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      supply_q <= 1'b0;
      vbus_q   <= 1'b0;
    end else if (clk_en) begin
      supply_q <= supply_ok;
      vbus_q   <= vbus_ok;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_reset_pulse <= 1'b0;
      serial_ready    <= 1'b0;
    end else if (clk_en) begin
      reg_reset_pulse <= supply_ok & ~supply_q;
      serial_ready    <= supply_ok;   // Host may access once a supply is up
    end
  end

  // ----------------------------------------------------------------
  // Host control bits
  // ----------------------------------------------------------------
  logic por_clr;
  assign por_clr = supply_ok & ~supply_q;

  // attach clears it; a host write in the same cycle wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      battery_switch_disable_bit <= 1'b0;
      watchdog_timer_setting     <= `CPS_WDT_RESET;
    end else if (clk_en) begin
      if (host_wr) begin
        battery_switch_disable_bit <= host_wr_switch_disable;
        watchdog_timer_setting     <= host_wr_watchdog;
      end else if (por_clr) begin
        battery_switch_disable_bit <= 1'b0;
        watchdog_timer_setting     <= `CPS_WDT_RESET;
      end else if (attach) begin
        battery_switch_disable_bit <= 1'b0;
      end
    end
  end

  // shipping needs both fields in one write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shipping_mode <= 1'b0;
    end else if (clk_en) begin
      if (host_wr) begin
        shipping_mode <= host_wr_switch_disable & (host_wr_watchdog == 2'h0);
      end else if (attach) begin
        shipping_mode <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Battery path switch
  // ----------------------------------------------------------------
  logic ovl_off_q;

  // overload latch; overload beats a simultaneous attach
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovl_off_q <= 1'b0;
    end else if (clk_en) begin
      if (ovl) begin
        ovl_off_q <= 1'b1;
      end else if (attach) begin
        ovl_off_q <= 1'b0;
      end
    end
  end

  // open at once on overload, not waiting for the latch
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      battery_path_switch_on <= 1'b0;
    end else if (clk_en) begin
      battery_path_switch_on <= supply_ok & depl_ok & ~ovl & ~ovl_off_q
                                & ~battery_switch_disable_bit;
    end
  end

  // ----------------------------------------------------------------
  // Bias regulator conditions and delay
  // ----------------------------------------------------------------
  logic                  bias_cond;
  logic [`CPS_CNT_W-1:0] dly_q;
  logic                  dly_done;

  // sleep comparator must match the mode
  assign bias_cond = vbus_ok & (boost ? ~sleep_ok : sleep_ok);
  assign dly_done  = (dly_q == `CPS_CNT_W'(BIAS_DLY_CYC - 1));

  // delay runs only while conditions hold
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_q <= '0;
    end else if (clk_en) begin
      if (!bias_cond) begin
        dly_q <= '0;
      end else if (!dly_done) begin
        dly_q <= dly_q + `CPS_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-up state machine
  // ----------------------------------------------------------------
  cps_pkg::cps_state_t   st_q;
  cps_pkg::cps_state_t   st_d;
  logic [`CPS_CNT_W-1:0] retry_q;
  logic                  retry_done;
  assign retry_done = (retry_q == `CPS_CNT_W'(RETRY_CYC - 1));

  // input checked before bias, limit before buck
  always_comb begin
    st_d = st_q;
    case (st_q)
      cps_pkg::CPS_ST_OFF: begin
        if (vbus_ok) begin
          st_d = cps_pkg::CPS_ST_HIZ;
        end else if (vbat_ok) begin
          st_d = cps_pkg::CPS_ST_BAT;
        end
      end
      cps_pkg::CPS_ST_BAT: begin
        if (vbus_ok) begin
          st_d = cps_pkg::CPS_ST_HIZ;
        end else if (!vbat_ok) begin
          st_d = cps_pkg::CPS_ST_OFF;
        end
      end
      // wait in high impedance until all conditions met
      cps_pkg::CPS_ST_HIZ: begin
        if (!vbus_ok) begin
          st_d = vbat_ok ? cps_pkg::CPS_ST_BAT : cps_pkg::CPS_ST_OFF;
        end else if (bias_cond && dly_done) begin
          st_d = boost ? cps_pkg::CPS_ST_BOOST : cps_pkg::CPS_ST_QUALIFY;
        end
      end
      // start buck only on a good source
      cps_pkg::CPS_ST_QUALIFY: begin
        st_d = src_ok ? cps_pkg::CPS_ST_RUN : cps_pkg::CPS_ST_RETRY;
      end
      cps_pkg::CPS_ST_RETRY: begin
        if (retry_done) begin
          st_d = cps_pkg::CPS_ST_QUALIFY;
        end
      end
      cps_pkg::CPS_ST_RUN,
      cps_pkg::CPS_ST_BOOST: begin
        st_d = st_q;
      end
      default: begin
        st_d = cps_pkg::CPS_ST_OFF;
      end
    endcase
    // losing any condition drops back to high impedance
    if (st_q != cps_pkg::CPS_ST_OFF && st_q != cps_pkg::CPS_ST_BAT
        && st_q != cps_pkg::CPS_ST_HIZ && !bias_cond) begin
      st_d = cps_pkg::CPS_ST_HIZ;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= cps_pkg::CPS_ST_OFF;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      retry_q <= '0;
    end else if (clk_en) begin
      if (st_q != cps_pkg::CPS_ST_RETRY || retry_done) begin
        retry_q <= '0;
      end else begin
        retry_q <= retry_q + `CPS_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs from state
  // ----------------------------------------------------------------
  logic bias_on;
  assign bias_on = (st_d == cps_pkg::CPS_ST_QUALIFY) || (st_d == cps_pkg::CPS_ST_RETRY)
                   || (st_d == cps_pkg::CPS_ST_RUN) || (st_d == cps_pkg::CPS_ST_BOOST);

  // high impedance whenever input present but bias off
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      internal_bias_regulator_en <= 1'b0;
      high_impedance_state       <= 1'b0;
      buck_enable                <= 1'b0;
    end else if (clk_en) begin
      internal_bias_regulator_en <= bias_on;
      high_impedance_state       <= (st_d == cps_pkg::CPS_ST_HIZ);
      buck_enable                <= (st_d == cps_pkg::CPS_ST_RUN);
    end
  end

  // power good and one interrupt per pass
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_good_status_bit <= 1'b0;
      power_good_output_n   <= 1'b1;
      host_int_pulse        <= 1'b0;
    end else if (clk_en) begin
      power_good_status_bit <= (st_d == cps_pkg::CPS_ST_RUN);
      power_good_output_n   <= ~(st_d == cps_pkg::CPS_ST_RUN);
      host_int_pulse        <= (st_q == cps_pkg::CPS_ST_QUALIFY) & src_ok & bias_cond;
    end else begin
      host_int_pulse        <= 1'b0;  // Never stretch a pulse across a freeze
    end
  end

endmodule : cps_sequencer

// ### bench/cps_seq_props.sv
// ----------------------------------------------------------------
// Port checker for the power-up sequencer
// ----------------------------------------------------------------
module cps_seq_props #(
  parameter int unsigned BIAS_DLY_CYC = 20
) (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       vbus_above_release,
  input wire logic       boost_request_pin,
  input wire logic       overload_detect,
  input wire logic       host_wr,
  input wire logic       host_wr_switch_disable,
  input wire logic [1:0] host_wr_watchdog,
  input wire logic       reg_reset_pulse,
  input wire logic       battery_switch_disable_bit,
  input wire logic       shipping_mode,
  input wire logic       battery_path_switch_on,
  input wire logic       internal_bias_regulator_en,
  input wire logic       high_impedance_state,
  input wire logic       buck_enable,
  input wire logic       power_good_status_bit,
  input wire logic       power_good_output_n,
  input wire logic       host_int_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned hiz_run_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Length of the current high impedance stretch; the bias delay is judged on it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hiz_run_q <= 0;
    end else begin
      hiz_run_q <= high_impedance_state ? hiz_run_q + 1 : 0;
    end
  end

  rst_pulse_a:
    assert property (reg_reset_pulse |=> !reg_reset_pulse) else $error("reset pulse too long");
  bias_bat_a:
    assert property (!vbus_above_release [*4] |-> !internal_bias_regulator_en)
      else $error("bias on without input");
  ovl_open_a:
    assert property ($rose(overload_detect) |-> ##[1:4] !battery_path_switch_on)
      else $error("switch not opened on overload");
  dis_write_a:
    assert property (host_wr && host_wr_switch_disable |=> battery_switch_disable_bit)
      else $error("disable write lost");
  dis_open_a:
    assert property (battery_switch_disable_bit |=> !battery_path_switch_on)
      else $error("switch closed while disabled");
  ship_entry_a:
    assert property (host_wr && host_wr_switch_disable && host_wr_watchdog == 2'h0
      |=> shipping_mode) else $error("shipping mode not entered");
  bias_delay_a:
    assert property ($rose(internal_bias_regulator_en) && !boost_request_pin
      |-> hiz_run_q + 3 >= BIAS_DLY_CYC) else $error("bias came up early");
  hiz_off_a:
    assert property (high_impedance_state |-> !internal_bias_regulator_en && !buck_enable)
      else $error("bias on in high impedance");
  buck_bias_a:
    assert property (buck_enable |-> internal_bias_regulator_en) else $error("buck without bias");
  pg_raise_a:
    assert property ($rose(power_good_status_bit) |-> host_int_pulse && !power_good_output_n)
      else $error("power good without pin or interrupt");
  int_pulse_a:
    assert property (host_int_pulse |=> !host_int_pulse) else $error("interrupt pulse too long");
endmodule : cps_seq_props

bind cps_sequencer cps_seq_props #(.BIAS_DLY_CYC(BIAS_DLY_CYC)) cps_seq_props_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .vbus_above_release(vbus_above_release),
  .boost_request_pin(boost_request_pin), .overload_detect(overload_detect),
  .host_wr(host_wr), .host_wr_switch_disable(host_wr_switch_disable),
  .host_wr_watchdog(host_wr_watchdog), .reg_reset_pulse(reg_reset_pulse),
  .battery_switch_disable_bit(battery_switch_disable_bit), .shipping_mode(shipping_mode),
  .battery_path_switch_on(battery_path_switch_on),
  .internal_bias_regulator_en(internal_bias_regulator_en),
  .high_impedance_state(high_impedance_state), .buck_enable(buck_enable),
  .power_good_status_bit(power_good_status_bit), .power_good_output_n(power_good_output_n),
  .host_int_pulse(host_int_pulse));

// ### bench/cps_host_model.sv
// ----------------------------------------------------------------
// Host processor issuing control writes
// ----------------------------------------------------------------
module cps_host_model (
  input wire logic  ref_clk,
  input wire logic  reset_n,
  input wire logic  go,
  input wire logic  ship,
  input wire logic  want_dis,
  input wire logic  battery_present,
  output logic       host_wr,
  output logic       host_wr_switch_disable,
  output logic [1:0] host_wr_watchdog
);
  timeunit 1ns;
  timeprecision 1ps;

  // One write per request; idle data wanders so stale values never look valid
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_wr                <= 1'b0;
      host_wr_switch_disable <= 1'b0;
      host_wr_watchdog       <= 2'h3;
    end else if (go && !host_wr) begin
      host_wr                <= 1'b1;
      host_wr_switch_disable <= want_dis | ship | !battery_present;
      host_wr_watchdog       <= ship ? 2'h0 : 2'h3;
    end else begin
      host_wr                <= 1'b0;
      host_wr_switch_disable <= ~host_wr_switch_disable;
      host_wr_watchdog       <= ~host_wr_watchdog;
    end
  end
endmodule : cps_host_model

// ### bench/cps_sequencer_tb.sv
module cps_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
  logic       vbus_above_release = 1'b0, vbat_above_release = 1'b0;
  logic       vbat_above_depletion = 1'b0, vbus_above_sleep_exit = 1'b0;
  logic       boost_request_pin = 1'b0, overload_detect = 1'b0, source_good = 1'b0;
  logic       go = 1'b0, ship = 1'b0, want_dis = 1'b0, seen;
  logic       host_wr, host_wr_switch_disable, reg_reset_pulse, serial_ready;
  logic       battery_switch_disable_bit, shipping_mode, battery_path_switch_on;
  logic       internal_bias_regulator_en, high_impedance_state, buck_enable;
  logic       power_good_status_bit, power_good_output_n, host_int_pulse;
  logic [1:0] host_wr_watchdog, watchdog_timer_setting;
  int         err_total = 0;
  int         comparisons = 0;

  always #4 ref_clk = ~ref_clk;

  // Short counts keep the run brief
  cps_sequencer #(.BIAS_DLY_CYC(20), .RETRY_CYC(30)) cps_sequencer_i (.*);
  cps_host_model cps_host_model_i (.ref_clk(ref_clk), .reset_n(reset_n), .go(go), .ship(ship),
    .want_dis(want_dis), .battery_present(vbat_above_depletion), .host_wr(host_wr),
    .host_wr_switch_disable(host_wr_switch_disable), .host_wr_watchdog(host_wr_watchdog));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic host_write(input logic s, input logic d);
    @(posedge ref_clk);
    go <= 1'b1;
    ship <= s;
    want_dis <= d;
    @(posedge ref_clk);
    go <= 1'b0;
    cyc(2);
  endtask : host_write

  task automatic plug(input logic v);
    @(posedge ref_clk);
    vbus_above_release <= v;
    vbus_above_sleep_exit <= v;
    cyc(6);
  endtask : plug

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_battery;
    seen = 1'b0;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    vbat_above_release <= 1'b1;
    vbat_above_depletion <= 1'b1;
    // Frozen clock enable must hold off the power-on response
    cyc(5);
    chk({serial_ready, battery_path_switch_on, reg_reset_pulse}, 3'h0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    repeat (6) begin
      cyc(1);
      seen = seen | reg_reset_pulse;
    end
    chk(seen, 1);
    chk(serial_ready, 1);
    chk(battery_path_switch_on, 1);
    chk(internal_bias_regulator_en, 0);
  endtask : t_battery

  task automatic t_overload;
    @(posedge ref_clk);
    overload_detect <= 1'b1;
    cyc(5);
    overload_detect <= 1'b0;
    cyc(10);
    chk(battery_path_switch_on, 0);
    plug(1'b1);
    chk(battery_path_switch_on, 1);
    plug(1'b0);
  endtask : t_overload

  task automatic t_host;
    vbat_above_depletion <= 1'b0;
    host_write(1'b0, 1'b0);
    chk(battery_switch_disable_bit, 1);
    vbat_above_depletion <= 1'b1;
    host_write(1'b0, 1'b0);
    cyc(3);
    chk({battery_switch_disable_bit, battery_path_switch_on}, 2'h1);
    host_write(1'b0, 1'b1);
    chk({battery_path_switch_on, shipping_mode}, 2'h0);
    host_write(1'b1, 1'b1);
    chk({shipping_mode, watchdog_timer_setting}, 3'h4);
    plug(1'b1);
    chk({battery_switch_disable_bit, shipping_mode, battery_path_switch_on}, 3'h1);
    plug(1'b0);
  endtask : t_host

  task automatic t_input;
    plug(1'b1);
    chk({high_impedance_state, internal_bias_regulator_en}, 2'h2);
    cyc(10);
    chk(internal_bias_regulator_en, 0);
    for (int i = 0; i < 12 && !internal_bias_regulator_en; i++) cyc(1);
    chk({internal_bias_regulator_en, buck_enable}, 2'h2);
    source_good <= 1'b1;
    cyc(15);
    chk(buck_enable, 0);
    for (int i = 0; i < 40 && !buck_enable; i++) cyc(1);
    chk({buck_enable, power_good_status_bit, power_good_output_n, host_int_pulse}, 4'hD);
    vbus_above_sleep_exit <= 1'b0;
    cyc(5);
    chk({high_impedance_state, internal_bias_regulator_en, buck_enable}, 3'h4);
    source_good <= 1'b0;
    plug(1'b0);
  endtask : t_input

  task automatic t_boost;
    boost_request_pin <= 1'b1;
    vbus_above_release <= 1'b1;
    for (int i = 0; i < 40 && !internal_bias_regulator_en; i++) cyc(1);
    chk({internal_bias_regulator_en, buck_enable, power_good_status_bit}, 3'h4);
    boost_request_pin <= 1'b0;
    plug(1'b0);
  endtask : t_boost

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // Reset values are looked at while reset is still held
  initial begin
    cyc(6);
    chk({watchdog_timer_setting, power_good_output_n, battery_path_switch_on}, 4'h6);
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(2);
    t_battery();
    t_overload();
    t_host();
    t_input();
    t_boost();
    give_verdict();
  end

  // Hang guard, far beyond the few hundred cycles the scenarios need
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule : cps_sequencer_tb
